// file: core/smb_check_consts.vh
// constants for the smbus check-byte, timeout and stop-wake block
// Operation
// R1 - low and extension timeouts step 2048 clocks, idle 4; limit is field plus one
// R2 - software sets byte ack control for slave transmit with check byte
// R3 - slave transmit: count includes check byte, count-1 requests, then code sent
// R4 - reload mode disables the check-byte request in every direction
// R5 - slave receive: software uses reload per byte, then check request
// R6 - slave receive: byte after count-1 compared; nack on mismatch, ack on match
// R7 - received check byte lands in receive data and sets receive full
// R8 - mismatch sets mismatch flag; error interrupt when enabled
// R9 - master transmit: software sets request and count before start
// R10 - master transmit with auto stop: stop right after the check byte
// R11 - master transmit without auto stop: complete flag and clock held low
// R12 - master receive with auto stop: check, nack the byte, then stop
// R13 - master receive without auto stop: check, complete flag, clock held low
// R14 - software enables stop wake and picks the internal oscillator
// R15 - start during stop: oscillator on, clock held until it runs
// R16 - address match while waking: hold clock until match flag cleared
// R17 - address mismatch while waking: oscillator off, no wake
// R18 - no oscillator request when kernel is system clock or wake disabled
// R19 - nonzero noise filter length cancels the stop-wake enable
// R20 - software keeps stretching on for wake; else disables before stop
// R21 - software avoids stop during master or addressed transfers
// R22 - check code is crc-8, poly x^8+x^2+x+1, over every message byte
// R23 - idle select 0 detects clock low, 1 detects both lines high
// R24 - check code accumulation restarts at every start or repeated start
`ifndef SMB_CHECK_CONSTS_VH
`define SMB_CHECK_CONSTS_VH

// ********************************************
// register offsets
// ********************************************
`define OFF_CTRL 8'h00
`define OFF_COUNT 8'h04
`define OFF_TIMEOUT 8'h08
`define OFF_STATUS 8'h0C
`define OFF_CHECK 8'h10
`define OFF_RXDATA 8'h14
`define OFF_TXDATA 8'h18
`define OFF_CMD 8'h1C

// ********************************************
// control fields
// ********************************************
`define CTRL_BYTE_ACK 0
`define CTRL_CHECK_REQ 1
`define CTRL_RELOAD 2
`define CTRL_AUTO_STOP 3
`define CTRL_ERR_IRQ 4
`define CTRL_WAKE_EN 5
`define CTRL_KSEL_SYS 6
`define CTRL_FILT_LO 8
`define CTRL_FILT_HI 11
`define CTRL_RESET 12'h000
`define CMD_RESTART 0

// ********************************************
// timeout fields
// ********************************************
`define TO_A_LO 0
`define TO_A_HI 11
`define TO_IDLE_SEL 12
`define TO_A_ON 15
`define TO_B_LO 16
`define TO_B_HI 27
`define TO_B_ON 31
`define TO_RESET 32'h00000000
`define STEP_LONG 11'h7FF
`define STEP_IDLE 11'h003

// ********************************************
// status bits
// ********************************************
`define ST_RX_FULL 0
`define ST_TX_REQ 1
`define ST_DONE 2
`define ST_MISMATCH 3
`define ST_TIMEOUT 4
`define ST_ADDR 5
`define ST_STOP 6

`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

`endif

// file: core/crc8_step.v
// crc-8 accumulator, one byte per enable
`timescale 1ns/1ps
`default_nettype none
`include "smb_check_consts.vh"
module crc8_step (
	input wire mclk,
	input wire rst,
	input wire clr,
	input wire en,
	input wire [7:0] data,
	output reg [7:0] crc
);
	reg [7:0] next_crc;
	integer i;

	// msb first, whole byte folded in one cycle
	// R22 crc-8 polynomial
	always @* begin
		next_crc = crc ^ data;
		for (i = 0; i < 8; i = i + 1) begin
			if (next_crc[7]) begin
				next_crc = {next_crc[6:0], 1'b0} ^ `CRC_POLY;
			end else begin
				next_crc = {next_crc[6:0], 1'b0};
			end
		end
	end

	// clear beats a byte, though both cannot meet on a real bus
	always @(posedge mclk) begin
		if (rst || clr) begin
			crc <= `CRC_INIT;
		end else if (en) begin
			crc <= next_crc;
		end
	end
endmodule
`default_nettype wire

// file: core/smbus_check_wake.v
// smbus check byte, timeout and stop-wake extension
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "smb_check_consts.vh"
module smbus_check_wake (
	input wire mclk,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	output wire scl_out,
	output reg scl_oe_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire master_mode,
	input wire addr_match,
	input wire stretch_active,
	input wire in_stop,
	input wire osc_ready,
	output reg [7:0] tx_byte,
	output reg ack_force,
	output reg ack_nack,
	output reg stop_request,
	output reg restart_request,
	output reg osc_request,
	output reg wake_request,
	output reg err_irq
);
	localparam [3:0] W_IDLE = 4'b0001;
	localparam [3:0] W_OSC = 4'b0010;
	localparam [3:0] W_ADDR = 4'b0100;
	localparam [3:0] W_MATCH = 4'b1000;

	// ********************************************
	// pin sampling and bus events
	// ********************************************
	reg scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

	// two stages before use, third stage for edges
	always @(posedge mclk) begin
		if (rst) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end

	assign scl_out = 1'b0; // open drain, only ever pulls low

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_ev = scl_s & scl_d & ~sda_d & sda_s;

	// ********************************************
	// registers
	// ********************************************
	reg [11:0] ctrl;
	reg [7:0] transfer_count;
	reg [31:0] tmo;
	reg [7:0] tx_data;
	reg [7:0] rx_data_reg;
	reg rx_full_flag, tx_data_request, transfer_complete_flag;
	reg check_mismatch_flag, timeout_flag, addr_flag, stop_seen_flag;
	wire [7:0] check_code_reg;

	wire byte_ack_control = ctrl[`CTRL_BYTE_ACK];
	wire check_byte_request = ctrl[`CTRL_CHECK_REQ];
	wire reload_mode = ctrl[`CTRL_RELOAD];
	wire auto_stop_enable = ctrl[`CTRL_AUTO_STOP];
	wire error_irq_enable = ctrl[`CTRL_ERR_IRQ];
	wire stop_wakeup_enable = ctrl[`CTRL_WAKE_EN];
	wire kernel_sel_sys = ctrl[`CTRL_KSEL_SYS];
	wire [3:0] noise_filter_len = ctrl[`CTRL_FILT_HI:`CTRL_FILT_LO];
	wire [11:0] low_idle_limit = tmo[`TO_A_HI:`TO_A_LO];
	wire idle_select = tmo[`TO_IDLE_SEL];
	wire low_idle_timer_on = tmo[`TO_A_ON];
	wire [11:0] ext_limit = tmo[`TO_B_HI:`TO_B_LO];
	wire ext_timer_on = tmo[`TO_B_ON];

	// address decode
	wire wr_ctrl = reg_wr && (reg_addr == `OFF_CTRL);
	wire wr_count = reg_wr && (reg_addr == `OFF_COUNT);
	wire wr_tmo = reg_wr && (reg_addr == `OFF_TIMEOUT);
	wire wr_status = reg_wr && (reg_addr == `OFF_STATUS);
	wire wr_txdata = reg_wr && (reg_addr == `OFF_TXDATA);
	wire wr_restart = reg_wr && (reg_addr == `OFF_CMD)
		&& reg_wdata[`CMD_RESTART];
	wire rd_rxdata = reg_rd && (reg_addr == `OFF_RXDATA);

	// ********************************************
	// byte framing
	// ********************************************
	reg [3:0] bit_cnt;
	reg [6:0] shift;
	reg addr_phase, rw, involved, ack_low;
	reg [7:0] data_cnt;
	wire [7:0] rx_byte = {shift, sda_s};
	wire byte_done = scl_rise && (bit_cnt == 4'h7);
	wire ack_rise = scl_rise && (bit_cnt == 4'h8);
	wire boundary = scl_fall && (bit_cnt == 4'h9);

	// bit count restarts at any start; stop ends the frame
	always @(posedge mclk) begin
		if (rst || start_ev || stop_ev) begin
			bit_cnt <= 4'h0;
		end else if (scl_rise) begin
			bit_cnt <= bit_cnt + 4'h1;
		end else if (boundary) begin
			bit_cnt <= 4'h0;
		end
	end

	// shift in data and remember ack level
	always @(posedge mclk) begin
		if (rst) begin
			shift <= 7'h00;
			ack_low <= 1'b0;
		end else begin
			if (scl_rise && bit_cnt < 4'h7) begin
				shift <= {shift[5:0], sda_s};
			end
			if (ack_rise) begin
				ack_low <= ~sda_s;
			end
		end
	end

	// ********************************************
	// check byte position
	// ********************************************
	// R4 reload cancels request
	wire check_act = check_byte_request && !reload_mode
		&& (master_mode || byte_ack_control);
	wire [7:0] cnt_m1 = transfer_count - 8'h01;
	wire is_check = check_act && !addr_phase && (data_cnt == cnt_m1);
	wire [7:0] nidx = addr_phase ? 8'h00 : (data_cnt + 8'h01);
	wire next_is_check = check_act && (nidx == cnt_m1);
	wire more_data = reload_mode || (nidx < transfer_count);
	wire dev_tx = master_mode ? ~rw : rw;
	wire mismatch = is_check && !dev_tx && involved
		&& (rx_byte != check_code_reg);
	wire check_end = boundary && is_check && involved;

	// frame state: address byte, direction, involvement, data index
	always @(posedge mclk) begin
		if (rst || stop_ev) begin
			addr_phase <= 1'b0;
			involved <= 1'b0;
			rw <= 1'b0;
			data_cnt <= 8'h00;
		end else if (start_ev) begin
			addr_phase <= 1'b1;
			involved <= 1'b0;
			data_cnt <= 8'h00;
		end else begin
			if (byte_done && addr_phase) begin
				rw <= rx_byte[0];
				involved <= master_mode | addr_match;
			end
			if (wr_count) begin
				data_cnt <= 8'h00; // a new count starts a new run
			end else if (boundary && !addr_phase) begin
				data_cnt <= data_cnt + 8'h01;
			end
			if (boundary) begin
				addr_phase <= 1'b0;
			end
		end
	end

	// R24 restart at start
	// R22 every byte incl address
	crc8_step u_crc (
		.mclk(mclk),
		.rst(rst),
		.clr(start_ev),
		.en(byte_done),
		.data(rx_byte),
		.crc(check_code_reg)
	);

	// ********************************************
	// answers to the core engine
	// ********************************************
	// ack override lives from the 8th bit to the end of the ack slot
	always @(posedge mclk) begin
		if (rst || start_ev || stop_ev) begin
			ack_force <= 1'b0;
			ack_nack <= 1'b0;
		end else if (byte_done && is_check && !dev_tx && involved) begin
			// R6 forced ack by compare
			// R12 master always nacks
			ack_force <= 1'b1;
			ack_nack <= master_mode | mismatch;
		end else if (boundary) begin
			ack_force <= 1'b0;
			ack_nack <= 1'b0;
		end
	end

	// R3 check code replaces data
	always @(posedge mclk) begin
		if (rst) begin
			tx_byte <= 8'h00;
		end else begin
			tx_byte <= is_check ? check_code_reg : tx_data;
		end
	end

	// master end of message after the check byte
	always @(posedge mclk) begin
		if (rst) begin
			stop_request <= 1'b0;
			restart_request <= 1'b0;
		end else begin
			// R10 stop after check
			// R12 then stop
			stop_request <= check_end && master_mode && auto_stop_enable;
			restart_request <= wr_restart;
		end
	end

	// ********************************************
	// timeouts
	// ********************************************
	reg [10:0] a_pre, b_pre;
	reg [12:0] a_cnt, b_cnt;
	// R23 idle select picks condition
	wire a_cond = idle_select ? (scl_s & sda_s) : ~scl_s;
	// R1 step length
	wire [10:0] a_step = idle_select ? `STEP_IDLE : `STEP_LONG;
	wire a_tick = a_pre == a_step;
	wire b_cond = stretch_active | ~scl_oe_n;
	wire b_tick = b_pre == `STEP_LONG;
	wire b_clear = start_ev || stop_ev || (boundary && master_mode);
	// R1 limit is field plus one
	wire a_hit = a_cnt == ({1'b0, low_idle_limit} + 13'h0001);
	wire b_hit = b_cnt == ({1'b0, ext_limit} + 13'h0001);

	// low or idle timer restarts whenever the condition breaks
	always @(posedge mclk) begin
		if (rst || !low_idle_timer_on || !a_cond) begin
			a_pre <= 11'h000;
			a_cnt <= 13'h0000;
		end else if (!a_hit) begin
			a_pre <= a_tick ? 11'h000 : a_pre + 11'h001;
			if (a_tick) begin
				a_cnt <= a_cnt + 13'h0001;
			end
		end
	end

	// extension time is cumulative and pauses between stretches; start, stop and, in master mode, each byte boundary clear it
	always @(posedge mclk) begin
		if (rst || !ext_timer_on || b_clear) begin
			b_pre <= 11'h000;
			b_cnt <= 13'h0000;
		end else if (b_cond && !b_hit) begin
			b_pre <= b_tick ? 11'h000 : b_pre + 11'h001;
			if (b_tick) begin
				b_cnt <= b_cnt + 13'h0001;
			end
		end
	end

	// ********************************************
	// stop-mode wake
	// ********************************************
	reg [3:0] wstate;
	reg [3:0] next_wstate;
	reg wake_hit;
	// R19 filter cancels wake enable
	// R18 no request on system clock
	wire wake_ok = stop_wakeup_enable && (noise_filter_len == 4'h0)
		&& !kernel_sel_sys;

	always @* begin
		next_wstate = wstate;
		case (wstate)
			W_IDLE: begin
				// R15 start powers oscillator
				if (start_ev && in_stop && wake_ok) begin
					next_wstate = W_OSC;
				end
			end
			W_OSC: begin
				if (osc_ready) begin
					next_wstate = W_ADDR;
				end
			end
			W_ADDR: begin
				// R16 match holds clock
				// R17 mismatch drops oscillator
				if (stop_ev) begin
					next_wstate = W_IDLE;
				end else if (boundary) begin
					next_wstate = wake_hit ? W_MATCH : W_IDLE;
				end
			end
			W_MATCH: begin
				// R16 release on flag clear
				if (!addr_flag) begin
					next_wstate = W_IDLE;
				end
			end
			default: begin
				next_wstate = W_IDLE;
			end
		endcase
	end

	always @(posedge mclk) begin
		if (rst) begin
			wstate <= W_IDLE;
			wake_hit <= 1'b0;
		end else begin
			wstate <= next_wstate;
			if (byte_done && addr_phase) begin
				wake_hit <= addr_match;
			end
		end
	end

	// ********************************************
	// status flags, set wins over clear
	// ********************************************
	reg hold_done;
	wire done_set = check_end && master_mode && !auto_stop_enable;
	wire rx_set = byte_done && !addr_phase && !dev_tx && involved;
	wire tx_set = boundary && involved && dev_tx
		&& (addr_phase || !ack_low ? addr_phase : 1'b1)
		&& !(!addr_phase && is_check) && !next_is_check && more_data;
	wire to_set = a_hit || b_hit;
	wire addr_set = byte_done && addr_phase && addr_match && !master_mode;

	always @(posedge mclk) begin
		if (rst) begin
			rx_full_flag <= 1'b0;
			tx_data_request <= 1'b0;
			transfer_complete_flag <= 1'b0;
			check_mismatch_flag <= 1'b0;
			timeout_flag <= 1'b0;
			addr_flag <= 1'b0;
			stop_seen_flag <= 1'b0;
			hold_done <= 1'b0;
		end else begin
			// R7 check byte is ordinary data
			if (rx_set) rx_full_flag <= 1'b1;
			else if (rd_rxdata) rx_full_flag <= 1'b0;
			// R3 count-1 requests
			if (tx_set) tx_data_request <= 1'b1;
			else if (wr_txdata) tx_data_request <= 1'b0;
			// R11 complete and hold
			// R13 complete and hold
			if (done_set) transfer_complete_flag <= 1'b1;
			else if (wr_restart || (wr_status && reg_wdata[`ST_DONE]))
				transfer_complete_flag <= 1'b0;
			if (done_set) hold_done <= 1'b1;
			else if (wr_restart) hold_done <= 1'b0;
			// R8 mismatch flag
			if (byte_done && mismatch) check_mismatch_flag <= 1'b1;
			else if (wr_status && reg_wdata[`ST_MISMATCH])
				check_mismatch_flag <= 1'b0;
			if (to_set) timeout_flag <= 1'b1;
			else if (wr_status && reg_wdata[`ST_TIMEOUT])
				timeout_flag <= 1'b0;
			if (addr_set) addr_flag <= 1'b1;
			else if (wr_status && reg_wdata[`ST_ADDR]) addr_flag <= 1'b0;
			if (stop_ev) stop_seen_flag <= 1'b1;
			else if (wr_status && reg_wdata[`ST_STOP])
				stop_seen_flag <= 1'b0;
		end
	end

	// ********************************************
	// software writes and outputs
	// ********************************************
	always @(posedge mclk) begin
		if (rst) begin
			ctrl <= `CTRL_RESET;
			transfer_count <= 8'h00;
			tmo <= `TO_RESET;
			tx_data <= 8'h00;
			rx_data_reg <= 8'h00;
		end else begin
			if (wr_ctrl) ctrl <= reg_wdata[11:0];
			if (wr_count) transfer_count <= reg_wdata[7:0];
			if (wr_tmo) tmo <= reg_wdata;
			if (wr_txdata) tx_data <= reg_wdata[7:0];
			if (rx_set) rx_data_reg <= rx_byte;
		end
	end

	// clock hold, oscillator and wake lines
	always @(posedge mclk) begin
		if (rst) begin
			scl_oe_n <= 1'b1;
			osc_request <= 1'b0;
			wake_request <= 1'b0;
			err_irq <= 1'b0;
		end else begin
			// R15 hold until oscillator runs
			scl_oe_n <= !(wstate == W_OSC || wstate == W_MATCH || hold_done);
			osc_request <= (wstate != W_IDLE);
			wake_request <= (wstate == W_MATCH);
			// R8 error interrupt
			err_irq <= error_irq_enable
				&& (check_mismatch_flag || timeout_flag);
		end
	end

	// read data one cycle after the strobe, zero for unmapped
	always @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			if (reg_addr == `OFF_CTRL) reg_rdata <= {20'h00000, ctrl};
			else if (reg_addr == `OFF_COUNT)
				reg_rdata <= {24'h000000, transfer_count};
			else if (reg_addr == `OFF_TIMEOUT) reg_rdata <= tmo;
			else if (reg_addr == `OFF_STATUS)
				reg_rdata <= {25'h0000000, stop_seen_flag, addr_flag,
					timeout_flag, check_mismatch_flag,
					transfer_complete_flag, tx_data_request, rx_full_flag};
			else if (reg_addr == `OFF_CHECK)
				reg_rdata <= {24'h000000, check_code_reg};
			else if (reg_addr == `OFF_RXDATA)
				reg_rdata <= {24'h000000, rx_data_reg};
			else if (reg_addr == `OFF_TXDATA)
				reg_rdata <= {24'h000000, tx_data};
			else reg_rdata <= 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// file: tb/smbus_check_wake_props.sv
// concurrent checks on the ports of the smbus check and stop-wake block
`timescale 1ns/1ps
`default_nettype none
`include "smb_check_consts.vh"
module smbus_check_wake_props (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic in_stop,
	input wire logic scl_oe_n,
	input wire logic ack_force,
	input wire logic stop_request,
	input wire logic restart_request,
	input wire logic osc_request,
	input wire logic wake_request,
	input wire logic err_irq
);
	// ****************************************
	// control shadow and event causes
	// ****************************************
	logic [11:0] ctrl_s;
	logic wake_ok;
	logic check_on;
	logic err_en;
	logic cmd_go;

	// rebuilt from bus writes, so no internal state is peeked
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_s <= 12'h000;
		end else if (reg_wr && reg_addr == `OFF_CTRL) begin
			ctrl_s <= reg_wdata[11:0];
		end
	end

	// what must already hold when each output event appears
	assign wake_ok = ctrl_s[`CTRL_WAKE_EN] && !ctrl_s[`CTRL_KSEL_SYS]
		&& ctrl_s[`CTRL_FILT_HI:`CTRL_FILT_LO] == 4'h0 && in_stop;
	assign check_on = ctrl_s[`CTRL_CHECK_REQ] && !ctrl_s[`CTRL_RELOAD];
	assign err_en = ctrl_s[`CTRL_ERR_IRQ];
	assign cmd_go = reg_wr && reg_addr == `OFF_CMD && reg_wdata[0];

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ****************************************
	// assertions
	// ****************************************
	chk_stop_pulse:
		assert property (stop_request |=> !stop_request)
		else $error("stop request wider than one cycle");
	chk_restart_pulse:
		assert property (cmd_go |=> restart_request ##1 !restart_request)
		else $error("restart pulse missing or wide");
	chk_restart_release:
		assert property (restart_request |-> ##[0:3] scl_oe_n)
		else $error("clock hold kept after restart");
	chk_osc_gate:
		assert property ($rose(osc_request) |-> $past(wake_ok))
		else $error("oscillator requested while not allowed");
	chk_osc_hold:
		assert property ($rose(osc_request) |-> ##[0:2] !scl_oe_n)
		else $error("clock not held while oscillator starts");
	chk_wake_osc:
		assert property ($rose(wake_request) |-> osc_request)
		else $error("wake without oscillator");
	chk_err_gate:
		assert property (err_irq |-> $past(err_en))
		else $error("error interrupt while disabled");
	chk_ack_gate:
		assert property ($rose(ack_force) |-> $past(check_on))
		else $error("forced ack without active check");
endmodule

bind smbus_check_wake smbus_check_wake_props u_props (
	.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .in_stop(in_stop), .scl_oe_n(scl_oe_n),
	.ack_force(ack_force), .stop_request(stop_request),
	.restart_request(restart_request), .osc_request(osc_request),
	.wake_request(wake_request), .err_irq(err_irq)
);
`default_nettype wire

// file: tb/smbus_far_end.sv
// far-end agent framing bytes on the two-wire link
`timescale 1ns/1ps
`default_nettype none
module smbus_far_end (
	input wire logic scl_wire,
	input wire logic ack_force,
	input wire logic ack_nack,
	output logic scl_drv,
	output logic sda_drv,
	output logic seen_force,
	output logic seen_nack
);
	// quarter of the 125 ns link period; clock stands still between frames
	localparam realtime Q = 31.25;

	// both lines released, pull-ups give high
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
		seen_force = 1'b0;
		seen_nack = 1'b0;
	end

	// start or repeated start: data falls with the clock high
	task go_start;
		sda_drv = 1'b1;
		#Q scl_drv = 1'b1;
		wait (scl_wire === 1'b1);
		#Q sda_drv = 1'b0;
		#Q scl_drv = 1'b0;
		#Q;
	endtask

	// eight bits msb first plus ack slot; waits out any clock stretch
	task put_byte(input logic [7:0] b);
		logic [8:0] v;
		int i;
		v = {b, 1'b0};
		for (i = 8; i >= 0; i--) begin
			sda_drv = v[i];
			#Q scl_drv = 1'b1;
			wait (scl_wire === 1'b1);
			#Q seen_force = ack_force;
			seen_nack = ack_nack;
			#Q scl_drv = 1'b0;
			#Q;
		end
	endtask

	// stop: data rises with the clock high, then the link idles
	task go_stop;
		sda_drv = 1'b0;
		#Q scl_drv = 1'b1;
		wait (scl_wire === 1'b1);
		#Q sda_drv = 1'b1;
		#Q;
	endtask
endmodule
`default_nettype wire

// file: tb/smbus_check_byte_and_stop_wake_tb_top.sv
// self-checking bench for the smbus check and stop-wake block
`timescale 1ns/1ps
`default_nettype none
`include "smb_check_consts.vh"
`define CHECK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("ERROR %0t: got %h want %h", $time, (g), (e)); \
	end \
end
module smbus_check_byte_and_stop_wake_tb_top;
	logic mclk, rst, reg_wr, reg_rd, master_mode;
	logic addr_match, in_stop, osc_ready, stretch_active;
	logic [7:0] reg_addr;
	logic [7:0] c;
	logic [31:0] reg_wdata;
	logic [31:0] d;
	wire [31:0] reg_rdata;
	wire [7:0] tx_byte;
	wire scl_out, scl_oe_n, ack_force, ack_nack, stop_request;
	wire restart_request, osc_request, wake_request, err_irq;
	wire scl_drv, sda_drv, seen_force, seen_nack, scl_wire;
	int fails = 0;
	int n_compared = 0;
	int n_stops = 0;
	int k;
	int m;

	// open-drain clock: low while either party pulls it
	assign scl_wire = scl_drv & (scl_oe_n | scl_out);

	smbus_check_wake i_dut (
		.mclk(mclk), .rst(rst), .scl_in(scl_wire), .sda_in(sda_drv),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .master_mode(master_mode),
		.addr_match(addr_match), .stretch_active(stretch_active),
		.in_stop(in_stop), .osc_ready(osc_ready), .tx_byte(tx_byte),
		.ack_force(ack_force), .ack_nack(ack_nack),
		.stop_request(stop_request), .restart_request(restart_request),
		.osc_request(osc_request), .wake_request(wake_request),
		.err_irq(err_irq)
	);
	smbus_far_end i_far (
		.scl_wire(scl_wire), .ack_force(ack_force), .ack_nack(ack_nack),
		.scl_drv(scl_drv), .sda_drv(sda_drv), .seen_force(seen_force),
		.seen_nack(seen_nack)
	);

	always #5 mclk = ~mclk;

	// count stop pulses; one-cycle wide so each edge counts once
	always @(posedge mclk) begin
		if (stop_request === 1'b1) n_stops++;
	end

	// one write cycle, then one idle cycle
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// read data taken in the cycle after the strobe only
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		v = reg_rdata;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, d);
		`CHECK(d, e)
	endtask

	// reference crc-8 step, poly 0x07, msb first
	function automatic logic [7:0] crc8(input logic [7:0] s, b);
		logic [7:0] x;
		x = s ^ b;
		for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
		return x;
	endfunction

	task conclude;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog well beyond the expected run of about 75 us
	initial begin
		#300000;
		fails++;
		conclude;
	end

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		{reg_wr, reg_rd, master_mode, addr_match} = 4'h0;
		{in_stop, osc_ready, stretch_active} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rchk(`OFF_CTRL, 32'h0);
		rchk(`OFF_STATUS, 32'h0);
		rchk(8'h40, 32'h0);
		// slave receive: bad code, good code, then reload ignores the request
		addr_match <= 1'b1;
		for (m = 0; m < 3; m++) begin
			wr(`OFF_CTRL, m == 2 ? 32'h17 : 32'h13);
			wr(`OFF_COUNT, 32'h2);
			wr(`OFF_STATUS, 32'h7C);
			c = crc8(crc8(8'h00, 8'hA0), 8'h5A) ^ {7'h0, m == 0};
			i_far.go_start;
			i_far.put_byte(8'hA0);
			i_far.put_byte(8'h5A);
			i_far.put_byte(c);
			`CHECK(seen_force, m < 2)
			if (m < 2) `CHECK(seen_nack, m == 0)
			rd(`OFF_STATUS, d);
			`CHECK(d[3], m == 0)
			`CHECK(err_irq, m == 0)
			`CHECK(d[0], 1'b1)
			rchk(`OFF_RXDATA, {24'h0, c});
			i_far.go_stop;
		end
		// slave transmit: one data request, then the code goes out
		wr(`OFF_CTRL, 32'h03);
		wr(`OFF_COUNT, 32'h2);
		i_far.go_start;
		i_far.put_byte(8'hA1);
		rd(`OFF_STATUS, d);
		`CHECK(d[1], 1'b1)
		wr(`OFF_TXDATA, 32'h3C);
		i_far.put_byte(8'h3C);
		rd(`OFF_STATUS, d);
		`CHECK(d[1], 1'b0)
		`CHECK(tx_byte, crc8(crc8(8'h00, 8'hA1), 8'h3C))
		i_far.go_stop;
		// master transmit and receive, with and without auto stop
		@(posedge mclk);
		addr_match <= 1'b0;
		master_mode <= 1'b1;
		for (k = 0; k < 4; k++) begin
			n_stops = 0;
			wr(`OFF_CTRL, {28'h0, k[0], 3'b010});
			wr(`OFF_COUNT, k[1] ? 32'h2 : 32'h1);
			i_far.go_start;
			c = crc8(8'h00, {7'h50, k[1]});
			i_far.put_byte({7'h50, k[1]});
			if (k[1]) begin
				i_far.put_byte(8'h5A);
				c = crc8(c, 8'h5A);
			end else begin
				// pins reach the design through synchronisers
				repeat (4) @(posedge mclk);
				`CHECK(tx_byte, c)
			end
			i_far.put_byte(c);
			repeat (6) @(posedge mclk);
			if (k[0]) begin
				`CHECK(n_stops, 1)
				if (k[1]) `CHECK(seen_nack, 1'b1)
			end else begin
				`CHECK(scl_oe_n, 1'b0)
				`CHECK(n_stops, 0)
				rd(`OFF_STATUS, d);
				`CHECK(d[2], 1'b1)
				wr(`OFF_CMD, 32'h1);
				repeat (3) @(posedge mclk);
				`CHECK(scl_oe_n, 1'b1)
			end
			i_far.go_stop;
		end
		// bus idle in steps of 4, clock low in steps of 2048
		master_mode <= 1'b0;
		for (k = 0; k < 2; k++) begin
			wr(`OFF_TIMEOUT, k ? 32'h00008000 : 32'h00009001);
			wr(`OFF_STATUS, 32'h7C);
			if (k) i_far.go_start;
			repeat (k ? 2000 : 2) @(posedge mclk);
			rd(`OFF_STATUS, d);
			`CHECK(d[4], 1'b0)
			repeat (k ? 100 : 8) @(posedge mclk);
			rd(`OFF_STATUS, d);
			`CHECK(d[4], 1'b1)
		end
		// cumulative extension: one step of 2048 while the core stretches
		wr(`OFF_TIMEOUT, 32'h80000000);
		wr(`OFF_STATUS, 32'h7C);
		stretch_active <= 1'b1;
		repeat (2000) @(posedge mclk);
		rd(`OFF_STATUS, d);
		`CHECK(d[4], 1'b0)
		repeat (100) @(posedge mclk);
		rd(`OFF_STATUS, d);
		`CHECK(d[4], 1'b1)
		stretch_active <= 1'b0;
		wr(`OFF_TIMEOUT, 32'h0);
		i_far.go_stop;
		// stop-wake: match, mismatch, system clock, noise filter on
		for (k = 0; k < 4; k++) begin
			wr(`OFF_CTRL, k == 2 ? 32'h60 : k == 3 ? 32'h120 : 32'h20);
			wr(`OFF_STATUS, 32'h7C);
			in_stop <= 1'b1;
			osc_ready <= 1'b0;
			addr_match <= k == 0;
			i_far.go_start;
			repeat (4) @(posedge mclk);
			`CHECK(osc_request, k < 2)
			`CHECK(scl_oe_n, k >= 2)
			osc_ready <= 1'b1;
			i_far.put_byte(8'hA0);
			repeat (6) @(posedge mclk);
			`CHECK(wake_request, k == 0)
			`CHECK(osc_request, k == 0)
			if (k == 0) begin
				`CHECK(scl_oe_n, 1'b0)
				wr(`OFF_STATUS, 32'h20);
				repeat (3) @(posedge mclk);
				`CHECK(scl_oe_n, 1'b1)
			end
			in_stop <= 1'b0;
			i_far.go_stop;
		end
		conclude;
	end
endmodule
`default_nettype wire
